//--- rtl/dotc_top.sv
// dac offset trim and clocking control: sample instant, parallel dac
// update, serial port word decode, offset trim registers, sleep controls
// assumes every pin input except rst and pair_ready is asynchronous to clk and is synchronised here
// Notes on behaviour
// - sample clock rising edge moves track-and-hold from track to hold.
// - dac update clock rising edge captures both channel words together.
// - each channel's 4-bit user trim is written only over the serial port.
// - trim bit 5 picks factory trim at 0, user trim at 1.
// - trim bit 4 under user trim: 0 lowers output, 1 raises it.
// - trim magnitude comes from word bits 3 to 0, loaded into offset register.
// - channel words are offset binary; midpoint 80h maps to zero output.
// - serial dac sleep low holds both serial channels in standby.
// - parallel dac sleep low turns off dacs and buffered references.
// - word bits 9..8 select offset A, serial 1, serial 0, offset B.
// - ten bits, msb first, sampled on serial clock rising edges.
`timescale 1ns/1ps
`default_nettype none
module dotc_top
	import dotc_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             converter_sample_clock,
	input  wire logic             dac_update_clock,
	input  wire logic [7:0]       channel_a_word,
	input  wire logic [7:0]       channel_b_word,
	input  wire logic             serial_clock,
	input  wire logic             serial_word_in,
	input  wire logic             serial_dac_sleep_n,
	input  wire logic             parallel_dac_sleep_n,
	input  wire logic             pair_ready,
	output var  logic             track_hold_hold,
	output var  logic             pair_valid,
	output var  dotc_pair_t       pair_data,
	output var  dotc_trim_t       trim_a,
	output var  dotc_trim_t       trim_b,
	output var  logic             serial_load_valid,
	output var  logic             serial_load_sel,
	output var  logic [7:0]       serial_load_word,
	output var  logic             serial_channels_standby,
	output var  logic             parallel_dacs_standby,
	output var  logic             buffered_channel_references
);
	// ==========================================================
	// synchronisers
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic [5:0] prev_reg;
	logic [7:0] a1_reg;
	logic [7:0] a2_reg;
	logic [7:0] b1_reg;
	logic [7:0] b2_reg;
	logic       adc_rise;
	logic       dac_rise;
	logic       sclk_rise;

	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg  <= '0;
		end else begin
			sync1_reg <= {parallel_dac_sleep_n, serial_dac_sleep_n,
				serial_word_in, serial_clock, dac_update_clock,
				converter_sample_clock};
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// words are stable around the update edge, so sampled alongside it
	always_ff @(posedge clk) begin
		a1_reg <= channel_a_word;
		a2_reg <= a1_reg;
		b1_reg <= channel_b_word;
		b2_reg <= b1_reg;
	end

	assign adc_rise  = sync2_reg[0] && !prev_reg[0];
	assign dac_rise  = sync2_reg[1] && !prev_reg[1];
	assign sclk_rise = sync2_reg[2] && !prev_reg[2];

	// ==========================================================
	// sample instant
	// hold from the rising edge until the clock falls again
	always_ff @(posedge clk) begin
		if (rst) begin
			track_hold_hold <= 1'b0;
		end else if (adc_rise) begin
			track_hold_hold <= 1'b1;
		end else if (!sync2_reg[0]) begin
			track_hold_hold <= 1'b0;
		end
	end

	// ==========================================================
	// parallel dac update
	dotc_pair_t cap_pair;
	logic       cap_ready;

	always_comb begin
		// offset binary to two's complement: flip the msb
		cap_pair.a = a2_reg ^ WORD_MIDPOINT;
		cap_pair.b = b2_reg ^ WORD_MIDPOINT;
	end

	// a full buffer drops the update edge; receiver stall must stay short
	dotc_pair_buffer i_dotc_pair_buffer (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (dac_rise && sync2_reg[5] && cap_ready),
		.in_ready  (cap_ready),
		.in_data   (cap_pair),
		.out_valid (pair_valid),
		.out_ready (pair_ready),
		.out_data  (pair_data)
	);

	// ==========================================================
	// serial port
	logic [SERIAL_WORD_BITS-1:0] shift_reg;
	logic [SERIAL_WORD_BITS-1:0] shift_next;
	logic [3:0]                  count_reg;
	logic                        word_done;

	assign shift_next = {shift_reg[SERIAL_WORD_BITS-2:0], sync2_reg[3]};
	// word completes on the tenth edge; extra edges are the host's fault
	assign word_done  = sclk_rise && (count_reg == BIT_COUNT_LAST - 4'h1);

	always_ff @(posedge clk) begin
		if (rst) begin
			shift_reg <= '0;
			count_reg <= 4'h0;
		end else if (sclk_rise) begin
			shift_reg <= shift_next;
			count_reg <= word_done ? 4'h0 : count_reg + 4'h1;
		end
	end

	// ==========================================================
	// offset trim registers
	dotc_trim_t word_trim;

	always_comb begin
		// bits 7 and 6 never looked at
		word_trim.user_src  = shift_next[TRIM_SRC_BIT];
		word_trim.raise     = shift_next[TRIM_DIR_BIT];
		word_trim.magnitude = shift_next[TRIM_MAG_HI:TRIM_MAG_LO];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			trim_a <= '0;
			trim_b <= '0;
		end else if (word_done) begin
			if (shift_next[DEST_HI:DEST_LO] == DEST_OFFSET_A) begin
				trim_a <= word_trim;
			end else if (shift_next[DEST_HI:DEST_LO] == DEST_OFFSET_B) begin
				trim_b <= word_trim;
			end
		end
	end

	// serial dac word handed on; latching lies outside this block
	always_ff @(posedge clk) begin
		if (rst) begin
			serial_load_valid <= 1'b0;
			serial_load_sel   <= 1'b0;
			serial_load_word  <= '0;
		end else begin
			serial_load_valid <= word_done &&
				(shift_next[DEST_HI] != shift_next[DEST_LO]);
			if (word_done) begin
				serial_load_sel  <= (shift_next[DEST_HI:DEST_LO] == DEST_SERIAL_1);
				serial_load_word <= shift_next[WORD_BITS-1:0];
			end
		end
	end

	// ==========================================================
	// sleep controls
	always_ff @(posedge clk) begin
		if (rst) begin
			serial_channels_standby     <= 1'b1;
			parallel_dacs_standby       <= 1'b1;
			buffered_channel_references <= 1'b0;
		end else begin
			serial_channels_standby     <= !sync2_reg[4];
			parallel_dacs_standby       <= !sync2_reg[5];
			buffered_channel_references <= sync2_reg[5];
		end
	end
endmodule
`default_nettype wire

//--- pkg/dotc_pkg.sv
// package for the dac offset trim and clocking block
// assumes a single 250 MHz clock domain; all pins except rst and pair_ready are asynchronous inputs
`default_nettype none
package dotc_pkg;
	localparam int          SERIAL_WORD_BITS = 10;
	localparam int          WORD_BITS        = 8;
	localparam int          TRIM_BITS        = 4;
	localparam logic [3:0]  BIT_COUNT_LAST   = 4'hA;
	// destination field of a serial word
	localparam int          DEST_HI          = 9;
	localparam int          DEST_LO          = 8;
	localparam logic [1:0]  DEST_OFFSET_A    = 2'h0;
	localparam logic [1:0]  DEST_SERIAL_1    = 2'h1;
	localparam logic [1:0]  DEST_SERIAL_0    = 2'h2;
	localparam logic [1:0]  DEST_OFFSET_B    = 2'h3;
	// offset trim word fields
	localparam int          TRIM_SRC_BIT     = 5;
	localparam int          TRIM_DIR_BIT     = 4;
	localparam int          TRIM_MAG_HI      = 3;
	localparam int          TRIM_MAG_LO      = 0;
	localparam logic [7:0]  WORD_MIDPOINT    = 8'h80;
	localparam logic [3:0]  TRIM_MAG_RESET   = 4'h0;
	localparam real         UPDATE_CLOCK_MHZ = 2.304;

	typedef struct packed {
		logic       user_src;
		logic       raise;
		logic [3:0] magnitude;
	} dotc_trim_t;

	typedef struct packed {
		logic signed [7:0] a;
		logic signed [7:0] b;
	} dotc_pair_t;
endpackage
`default_nettype wire

//--- rtl/dotc_pair_buffer.sv
// two-entry valid/ready buffer for captured dac word pairs
// assumes same-clock producer and consumer
`timescale 1ns/1ps
`default_nettype none
module dotc_pair_buffer
	import dotc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       in_valid,
	output var  logic       in_ready,
	input  wire dotc_pair_t in_data,
	output var  logic       out_valid,
	input  wire logic       out_ready,
	output var  dotc_pair_t out_data
);
	dotc_pair_t mem_reg [2];
	logic       wr_ptr_reg;
	logic       rd_ptr_reg;
	logic [1:0] count_reg;
	logic       push;
	logic       pop;

	assign push = in_valid && in_ready;
	assign pop  = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg  <= 2'h0;
			in_ready   <= 1'b1;
			out_valid  <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			if (push && !pop) begin
				count_reg <= count_reg + 2'h1;
				in_ready  <= (count_reg == 2'h0);
				out_valid <= 1'b1;
			end else if (pop && !push) begin
				count_reg <= count_reg - 2'h1;
				in_ready  <= 1'b1;
				out_valid <= (count_reg == 2'h2);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// output word read from the head entry through a register
	always_ff @(posedge clk) begin
		if (rst) begin
			out_data <= '0;
		end else if (pop && count_reg == 2'h2) begin
			out_data <= mem_reg[~rd_ptr_reg];
		end else if (push && (count_reg == 2'h0 ||
				(pop && count_reg == 2'h1))) begin
			out_data <= in_data;
		end
	end
endmodule
`default_nettype wire

//--- tb/dotc_host.sv
// host model: drives the serial clock and data, one word per call
// assumes the bench calls send just after a rising clk edge
`timescale 1ns/1ps
`default_nettype none
// ==========
// host serial port
module dotc_host (
	input  wire logic clk,
	output var  logic serial_clock,
	output var  logic serial_word_in
);
	initial begin
		serial_clock = 1'b0;
		serial_word_in = 1'b0;
	end
	// six clk per half period gives the 48 ns link clock
	task automatic send(input logic [9:0] w);
		for (int i = 9; i >= 0; i--) begin
			serial_word_in <= w[i];
			repeat (6) @(posedge clk);
			serial_clock <= 1'b1;
			repeat (6) @(posedge clk);
			serial_clock <= 1'b0;
		end
		serial_word_in <= 1'b0; // data idles low between words
	endtask
endmodule
`default_nettype wire

//--- tb/dotc_top_sva.sv
// checker for dotc_top, bound to its ports
// assumes the single clk domain with synchronous rst
`timescale 1ns/1ps
`default_nettype none
// ==========
// checker
module dotc_top_sva
	import dotc_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       converter_sample_clock,
	input wire logic       serial_clock,
	input wire logic       serial_dac_sleep_n,
	input wire logic       parallel_dac_sleep_n,
	input wire logic       pair_ready,
	input wire logic       track_hold_hold,
	input wire logic       pair_valid,
	input wire dotc_pair_t pair_data,
	input wire dotc_trim_t trim_a,
	input wire dotc_trim_t trim_b,
	input wire logic       serial_load_valid,
	input wire logic       serial_channels_standby,
	input wire logic       parallel_dacs_standby,
	input wire logic       buffered_channel_references
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	a_hold_on_edge: assert property (
		$rose(converter_sample_clock) |-> ##[1:6] track_hold_hold)
		else $error("hold not taken");
	a_pair_held: assert property (
		pair_valid && !pair_ready |=> pair_valid && $stable(pair_data))
		else $error("pair lost while stalled");
	a_trim_quiet: assert property (
		!serial_clock [*8] |=> $stable(trim_a) && $stable(trim_b))
		else $error("trim moved without word");
	a_load_quiet: assert property (
		!serial_clock [*8] |=> !serial_load_valid)
		else $error("load without word");
	a_par_sleep: assert property (
		!parallel_dac_sleep_n [*6] |-> parallel_dacs_standby)
		else $error("parallel not asleep");
	a_refs_off: assert property (
		parallel_dacs_standby |-> !buffered_channel_references)
		else $error("references on in sleep");
	a_par_wake: assert property (
		parallel_dac_sleep_n [*6] |-> buffered_channel_references)
		else $error("references not on");
	a_ser_sleep: assert property (
		!serial_dac_sleep_n [*6] |-> serial_channels_standby)
		else $error("serial not asleep");
	a_ser_wake: assert property (
		serial_dac_sleep_n [*6] |-> !serial_channels_standby)
		else $error("serial stuck asleep");
	c_hold: cover property ($rose(track_hold_hold));
	c_load: cover property (serial_load_valid);
	c_pair: cover property (pair_valid && pair_ready);
endmodule
bind dotc_top dotc_top_sva i_dotc_top_sva (.clk, .rst,
	.converter_sample_clock, .serial_clock, .serial_dac_sleep_n,
	.parallel_dac_sleep_n, .pair_ready, .track_hold_hold, .pair_valid,
	.pair_data, .trim_a, .trim_b, .serial_load_valid,
	.serial_channels_standby, .parallel_dacs_standby,
	.buffered_channel_references);
`default_nettype wire

//--- tb/test_dotc_top.sv
// bench for dotc_top: pins driven here, serial words by the host model
// assumes dotc_pkg, the design and dotc_host are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
	$display("unexpected %0t got %h", $time, a); end end
// ==========
// bench
module test_dotc_top
	import dotc_pkg::*;
;
	logic       clk = 1'b0, rst = 1'b1, pair_ready = 1'b0;
	logic       converter_sample_clock = 1'b0, dac_update_clock = 1'b0;
	logic       serial_dac_sleep_n = 1'b1, parallel_dac_sleep_n = 1'b1;
	logic [7:0] channel_a_word = 8'h00, channel_b_word = 8'hFF;
	wire logic  serial_clock, serial_word_in, track_hold_hold, pair_valid;
	wire logic  serial_load_valid, serial_load_sel, serial_channels_standby;
	wire logic  parallel_dacs_standby, buffered_channel_references;
	wire logic [7:0] serial_load_word;
	wire dotc_pair_t pair_data;
	wire dotc_trim_t trim_a, trim_b;
	logic [8:0] ld = 9'h000;
	int         err_total = 0, cmp_count = 0;
	always #2 clk = ~clk;
	always @(posedge clk) begin
		if (serial_load_valid) ld <= {serial_load_sel, serial_load_word};
	end
	dotc_host i_dotc_host (.clk, .serial_clock, .serial_word_in);
	dotc_top i_dotc_top (.clk, .rst, .converter_sample_clock,
		.dac_update_clock, .channel_a_word, .channel_b_word, .serial_clock,
		.serial_word_in, .serial_dac_sleep_n, .parallel_dac_sleep_n,
		.pair_ready, .track_hold_hold, .pair_valid, .pair_data, .trim_a,
		.trim_b, .serial_load_valid, .serial_load_sel, .serial_load_word,
		.serial_channels_standby, .parallel_dacs_standby,
		.buffered_channel_references);
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic upd();
		dac_update_clock <= 1'b1;
		wt(6);
		dac_update_clock <= 1'b0;
		wt(6);
	endtask
	task automatic report_and_stop();
		if (err_total == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// bits 7..6 set to ones must not leak into the trim
	task automatic t_trim();
		i_dotc_host.send(10'h0EF);
		wt(8);
		`CHK(trim_a, 6'h2F)
		i_dotc_host.send(10'h3B5);
		wt(8);
		`CHK(trim_b, 6'h35)
		`CHK(trim_a, 6'h2F)
		i_dotc_host.send(10'h053);
		wt(8);
		`CHK(trim_a.user_src, 1'b0)
	endtask
	task automatic t_load();
		i_dotc_host.send(10'h1A5);
		wt(8);
		`CHK(ld, 9'h1A5)
		i_dotc_host.send(10'h23C);
		wt(8);
		`CHK(ld, 9'h03C)
		`CHK(trim_b, 6'h35)
	endtask
	// third update finds the buffer full and is dropped
	task automatic t_pair();
		upd();
		channel_a_word <= 8'h80;
		channel_b_word <= 8'h01;
		wt(3);
		upd();
		channel_b_word <= 8'hFF;
		wt(3);
		upd();
		@(negedge clk);
		`CHK(pair_data, 16'h807F)
		@(posedge clk) pair_ready <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		`CHK(pair_data, 16'h0081)
		wt(2);
		@(negedge clk);
		`CHK(pair_valid, 1'b0)
	endtask
	task automatic t_sleep();
		pair_ready <= 1'b0;
		parallel_dac_sleep_n <= 1'b0;
		serial_dac_sleep_n <= 1'b0;
		upd();
		`CHK({parallel_dacs_standby, buffered_channel_references}, 2'h2)
		`CHK(serial_channels_standby, 1'b1)
		`CHK(pair_valid, 1'b0)
		parallel_dac_sleep_n <= 1'b1;
		serial_dac_sleep_n <= 1'b1;
		converter_sample_clock <= 1'b1;
		wt(8);
		`CHK({parallel_dacs_standby, serial_channels_standby}, 2'h0)
		`CHK(track_hold_hold, 1'b1)
		converter_sample_clock <= 1'b0;
		wt(8);
		`CHK(track_hold_hold, 1'b0)
	endtask
	initial begin
		wt(12);
		`CHK(serial_channels_standby, 1'b1)
		rst <= 1'b0;
		wt(4);
		t_trim();
		t_load();
		t_pair();
		t_sleep();
		report_and_stop();
	end
	initial begin
		wt(6000);
		err_total++;
		report_and_stop();
	end
endmodule
`default_nettype wire
